// [bench/serial_master_model.sv]
// Serial master model: makes the bit and frame clocks and captures output words
`timescale 1ns/1ns
module serial_master_model (
	// Reference clock and framing controls
	input wire logic ref_clk_i,
	input wire logic fmt_i,
	input wire logic [4:0] half_i,
	input wire logic [6:0] bits_i,
	input wire logic [7:0] stretch_i,
	// Link
	input wire logic serial_data_i,
	output logic serial_bit_clock_o,
	output logic frame_select_clock_o,
	output int frame_cnt_o
);
	logic [31:0] word_q [0:255];
	logic [31:0] shift_q;
	int i;

	// Clocks run from power-up and derive from the reference clock, so the frame stays locked
	initial
	begin
		serial_bit_clock_o = 1'b1;
		frame_select_clock_o = 1'b0;
		frame_cnt_o = 0;
		shift_q = 32'h0000_0000;
		// Let the framing controls settle first; a zero bit count would spin without time
		@(posedge ref_clk_i);
		forever
		begin
			for (i = 0; i < int'(bits_i); i++)
			begin
				@(posedge ref_clk_i);
				serial_bit_clock_o <= 1'b0;
				// Frame edges fall on bit clock falls; first half carries the left word
				if (i == 0 || i == int'(bits_i) / 2)
					frame_select_clock_o <= (i == 0) ^ fmt_i;
				repeat (int'(half_i) - 1) @(posedge ref_clk_i);
				@(posedge ref_clk_i);
				serial_bit_clock_o <= 1'b1;
				// Receiver takes each bit at the rising bit clock edge
				shift_q = {shift_q[30:0], serial_data_i};
				repeat (int'(half_i) - 1) @(posedge ref_clk_i);
			end
			// Extra hold moves the next frame edge against the reference clock
			repeat (int'(stretch_i)) @(posedge ref_clk_i);
			word_q[frame_cnt_o[7:0]] = shift_q;
			frame_cnt_o++;
		end
	end
endmodule // serial_master_model

// [bench/test_stereo_adc_serial_output_control.sv]
// Testbench for the stereo converter serial output block
`timescale 1ns/1ns
module test_stereo_adc_serial_output_control;
	import adc_serial_pkg::*;
	// Short valid delay keeps the run brief
	localparam int VALID = 4;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic supply_ok = 1'b0;
	logic serial_bit_clock;
	logic frame_select_clock;
	logic serial_data_o;
	logic sample_valid = 1'b0;
	logic [31:0] sample_data = 32'h0000_0000;
	logic sample_ready_o;
	logic fmt = 1'b0;
	logic [4:0] half = 5'h08;
	logic [6:0] bits = 7'h20;
	logic [7:0] stretch = 8'h00;
	int fc;
	int rel;
	int n_fail = 0;
	int n_tests = 0;

	adc_serial_out #(.VALID_FRAMES(VALID)) adc_serial_out_inst (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .paddr_i(paddr), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.supply_ok_i(supply_ok), .serial_bit_clock_i(serial_bit_clock), .frame_select_clock_i(frame_select_clock),
		.serial_data_o(serial_data_o), .sample_valid_i(sample_valid),
		.sample_data_i(sample_data), .sample_ready_o(sample_ready_o));

	serial_master_model serial_master_model_inst (
		.ref_clk_i(ref_clk_i), .fmt_i(fmt), .half_i(half), .bits_i(bits),
		.stretch_i(stretch), .serial_data_i(serial_data_o), .serial_bit_clock_o(serial_bit_clock),
		.frame_select_clock_o(frame_select_clock), .frame_cnt_o(fc));

	// 10 MHz system clock
	always #50 ref_clk_i = ~ref_clk_i;

	// Verdict and end of run
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// A wait that runs out ends the run
	task automatic stuck(input string what);
		check(what, 32'h0000_0000, 32'h0000_0001);
		finish_test();
	endtask

	// One APB transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r, output logic e);
		int k;
		@(posedge ref_clk_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		for (k = 0; k < 20; k++)
		begin
			@(posedge ref_clk_i);
			if (pready_o === 1'b1)
				break;
		end
		if (k == 20)
			stuck("apb ready");
		r = prdata_o;
		e = pslverr_o;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0000_0000, 4'h0, r, e);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, s, r, e);
	endtask

	// Bounded wait for a number of completed frames
	task automatic frames(input int n);
		int t;
		int k;
		t = fc + n;
		for (k = 0; k < n * 800 && fc < t; k++)
			@(posedge ref_clk_i);
		if (fc < t)
			stuck("frame wait");
	endtask

	function automatic logic [31:0] word(input int i);
		return {8'hA5, 8'(i), 8'h3C, 8'(i)};
	endfunction

	// One frame far too long: clock relation broken
	task automatic lose();
		stretch <= 8'h70;
		frames(1);
		stretch <= 8'h00;
		repeat (16) @(posedge ref_clk_i);
	endtask

	// Registers during the power hold, strobe and unmapped access
	task automatic t_regs();
		logic [31:0] r;
		logic e;
		rd(CTRL_OFS, r);
		check("ctrl reset", r, 32'h0000_0000);
		rd(STATUS_OFS, r);
		check("hold while supply low", 32'(r[ST_RESET_BIT]), 32'h0000_0001);
		wr(CTRL_OFS, 32'h0000_0003, 4'h0);
		rd(CTRL_OFS, r);
		check("ctrl without strobe", r, 32'h0000_0000);
		apb(1'b0, 8'h08, 32'h0000_0000, 4'h0, r, e);
		check("unmapped error", 32'(e), 32'h0000_0001);
		check("unmapped data", r, 32'h0000_0000);
		wr(CTRL_OFS, 32'h0000_0001 << CTRL_SKIP_BIT, 4'h1);
		rd(CTRL_OFS, r);
		check("ctrl skip", r, 32'h0000_0001 << CTRL_SKIP_BIT);
	endtask

	// Hold lasts 1024 system clocks after supply good, output zero meanwhile
	task automatic t_por();
		logic [31:0] r;
		logic bad;
		int k;
		bad = 1'b0;
		supply_ok <= 1'b1;
		for (k = 0; k < 1020; k++)
		begin
			@(posedge ref_clk_i);
			bad = bad | serial_data_o;
		end
		check("output in hold", 32'(bad), 32'h0000_0000);
		rd(STATUS_OFS, r);
		check("hold near 1024", 32'(r[ST_RESET_BIT]), 32'h0000_0001);
		repeat (12) @(posedge ref_clk_i);
		rd(STATUS_OFS, r);
		check("hold released", 32'(r[ST_RESET_BIT]), 32'h0000_0000);
		rel = fc;
	endtask

	// Fill buffer until refused, then valid delay, word order and underrun
	task automatic t_stream();
		logic [31:0] r;
		int n;
		int k;
		int f;
		@(posedge ref_clk_i);
		sample_valid <= 1'b1;
		sample_data <= word(0);
		n = 0;
		for (k = 0; k < 40; k++)
		begin
			@(posedge ref_clk_i);
			if (sample_ready_o !== 1'b1)
				break;
			n++;
			sample_data <= word(n);
		end
		sample_valid <= 1'b0;
		check("words accepted", 32'(n), 32'(FIFO_DEPTH));
		frames(VALID + 10);
		f = rel;
		while (f < fc && serial_master_model_inst.word_q[f] === 32'h0000_0000)
			f++;
		check("valid delay", 32'(f - rel >= VALID), 32'h0000_0001);
		for (k = 0; k < 4; k++)
			check("lj word", serial_master_model_inst.word_q[f + k], word(k));
		frames(18);
		rd(STATUS_OFS, r);
		check("underrun set", 32'(r[ST_UNDERRUN_BIT]), 32'h0000_0001);
		check("underrun output", serial_master_model_inst.word_q[fc - 1], 32'h0000_0000);
		check("ratio 512", 32'(r[ST_RATIO_LSB +: 2]), 32'(RATIO_512));
		check("bits 32", 32'(r[ST_BITS_LSB +: 7]), 32'(BITS_32));
		// Clear away from the left frame edge, where a fresh underrun would win
		repeat (16) @(posedge ref_clk_i);
		wr(STATUS_OFS, 32'h0000_0001 << ST_UNDERRUN_BIT, 4'h1);
		rd(STATUS_OFS, r);
		check("underrun clear", 32'(r[ST_UNDERRUN_BIT]), 32'h0000_0000);
	endtask

	// Small drift keeps lock; large drift drops it until resync
	task automatic t_drift();
		logic [31:0] r;
		stretch <= 8'h40;
		frames(1);
		stretch <= 8'h00;
		frames(2);
		rd(STATUS_OFS, r);
		check("lock small drift", 32'(r[ST_LOCK_BIT]), 32'h0000_0001);
		lose();
		rd(STATUS_OFS, r);
		check("lock lost", 32'(r[ST_LOCK_BIT]), 32'h0000_0000);
		frames(8);
		rd(STATUS_OFS, r);
		check("lock regained", 32'(r[ST_LOCK_BIT]), 32'h0000_0001);
	endtask

	// 384 fs ratio with 32-clock left-justified frames
	task automatic t_ratio();
		logic [31:0] r;
		half <= 5'h06;
		frames(8);
		rd(STATUS_OFS, r);
		check("ratio 384", 32'(r[ST_RATIO_LSB +: 2]), 32'(RATIO_384));
		check("lock 384", 32'(r[ST_LOCK_BIT]), 32'h0000_0001);
		half <= 5'h08;
	endtask

	// I2S refuses 32-clock frames: no lock and a zero output
	task automatic t_i2s();
		logic [31:0] r;
		wr(CTRL_OFS, 32'h0000_0003, 4'h1);
		fmt <= 1'b1;
		lose();
		frames(8);
		rd(STATUS_OFS, r);
		check("i2s 32 refused", 32'(r[ST_LOCK_BIT]), 32'h0000_0000);
		check("i2s output zero", serial_master_model_inst.word_q[fc - 1], 32'h0000_0000);
	endtask

	// Main sequence
	initial
	begin
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_por();
		t_stream();
		t_drift();
		t_ratio();
		t_i2s();
		finish_test();
	end
endmodule // test_stereo_adc_serial_output_control

// [design/adc_serial_out.sv]
// Serial output control of a stereo 16-bit converter: reset, sync, format, filter
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ns
module adc_serial_out #(
	parameter int VALID_FRAMES = adc_serial_pkg::VALID_FRAMES_DEF
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// APB slave
	input wire logic [7:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Pins
	input wire logic supply_ok_i,
	input wire logic serial_bit_clock_i,
	input wire logic frame_select_clock_i,
	output logic serial_data_o,
	// Converted samples, left in the upper half
	input wire logic sample_valid_i,
	input wire logic [adc_serial_pkg::STEREO_W-1:0] sample_data_i,
	output logic sample_ready_o
);
	import adc_serial_pkg::*;

	localparam int AW = SAMPLE_W + HPF_SHIFT;
	localparam logic [VCNT_W-1:0] VCNT_LAST = VCNT_W'(VALID_FRAMES - 1);

	// Absolute difference of two lengths
	function automatic logic [10:0] absdiff(input logic [10:0] a, input logic [10:0] b);
		absdiff = (a > b) ? a - b : b - a;
	endfunction

	// Nominal frame length for a ratio
	function automatic logic [10:0] ratio_len(input ratio_t r);
		case (r)
			RATIO_256: ratio_len = LEN_256;
			RATIO_384: ratio_len = LEN_384;
			RATIO_512: ratio_len = LEN_512;
			default: ratio_len = 11'h000;
		endcase
	endfunction

	// Classify a measured frame length; sync quantisation allows a small tolerance
	function automatic ratio_t ratio_of(input logic [10:0] len);
		if (absdiff(len, LEN_256) <= LEN_TOL) ratio_of = RATIO_256;
		else if (absdiff(len, LEN_384) <= LEN_TOL) ratio_of = RATIO_384;
		else if (absdiff(len, LEN_512) <= LEN_TOL) ratio_of = RATIO_512;
		else ratio_of = RATIO_NONE;
	endfunction

	// Legal bit clocks per frame for format and ratio
	function automatic logic framing_ok(input logic fmt, input ratio_t r, input logic [6:0] nb);
		case (nb)
			BITS_64: framing_ok = (r != RATIO_NONE);
			BITS_48: framing_ok = (r == RATIO_384);
			BITS_32: framing_ok = (r != RATIO_NONE) && !fmt;
			default: framing_ok = 1'b0;
		endcase
	endfunction

	// Drift threshold in system clocks for a given number of bit clocks
	function automatic logic [10:0] drift_limit(input logic [2:0] k, input logic [10:0] nom,
		input logic [6:0] nb);
		logic [13:0] prod;
		prod = {3'h0, nom} * {11'h000, k};
		drift_limit = (nb == 7'h00) ? 11'h000 : 11'(prod / {7'h00, nb});
	endfunction

	// Saturate a 17-bit difference into a sample word
	function automatic logic [15:0] sat16(input logic [16:0] v);
		if (v[16] != v[15]) sat16 = v[16] ? 16'h8000 : 16'h7FFF;
		else sat16 = v[15:0];
	endfunction

	// Pin synchronisers; bit 0 supply, bit 1 bit clock, bit 2 frame clock
	logic [2:0] s1_q, s2_q, s3_q, pin_q, pin_d, prev_q;
	always_comb
	begin
		for (int i = 0; i < 3; i++)
		begin
			pin_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : pin_q[i];
		end
	end
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
			s3_q <= 3'h0;
			pin_q <= 3'h0;
			prev_q <= 3'h0;
		end
		else
		begin
			s1_q <= {frame_select_clock_i, serial_bit_clock_i, supply_ok_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= pin_d;
			prev_q <= pin_q;
		end
	end

	logic bclk_fall, bclk_rise, frame_rise;
	assign bclk_fall = prev_q[1] && !pin_q[1];
	assign bclk_rise = !prev_q[1] && pin_q[1];
	assign frame_rise = !prev_q[2] && pin_q[2];

	// Power-on hold, counted on the system clock so it needs that clock running
	logic por_busy_q, por_busy_d, core_rst;
	logic [9:0] por_cnt_q, por_cnt_d;
	always_comb
	begin
		por_busy_d = por_busy_q;
		por_cnt_d = por_cnt_q;
		if (!pin_q[0])
		begin
			por_busy_d = 1'b1;
			por_cnt_d = 10'h000;
		end
		else if (por_busy_q)
		begin
			if (por_cnt_q == POR_LAST)
				por_busy_d = 1'b0;
			else
				por_cnt_d = por_cnt_q + 10'h001;
		end
	end
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			por_busy_q <= 1'b1;
			por_cnt_q <= 10'h000;
		end
		else
		begin
			por_busy_q <= por_busy_d;
			por_cnt_q <= por_cnt_d;
		end
	end
	assign core_rst = rst_i || por_busy_q;

	// Frame measurement and synchronisation tracking
	sync_state_t state_q, state_d;
	ratio_t ratio_q, ratio_d, meas_ratio;
	logic [10:0] flen_q, flen_d, drift, loss_lim, keep_lim;
	logic [6:0] nbits_q, nbits_d, bits_q, bits_d, meas_bits;
	logic [1:0] ctrl_q, ctrl_d;
	logic fmt, dc_skip, locked;
	assign fmt = ctrl_q[CTRL_FMT_BIT];
	assign dc_skip = ctrl_q[CTRL_SKIP_BIT];
	assign meas_bits = nbits_q + {6'h00, bclk_rise};
	assign meas_ratio = ratio_of(flen_q);
	assign drift = absdiff(flen_q, ratio_len(ratio_q));
	assign loss_lim = drift_limit(LOSS_BITS, ratio_len(ratio_q), bits_q);
	assign keep_lim = drift_limit(KEEP_BITS, ratio_len(ratio_q), bits_q);
	assign locked = (state_q == SYNC_LOCK);
	always_comb
	begin
		state_d = state_q;
		ratio_d = ratio_q;
		bits_d = bits_q;
		flen_d = (flen_q == FLEN_MAX) ? flen_q : flen_q + 11'h001;
		nbits_d = (nbits_q == BITS_MAX) ? nbits_q : nbits_q + {6'h00, bclk_rise};
		if (flen_q == FLEN_MAX)
			state_d = SYNC_HUNT; // Frame clock stopped
		if (frame_rise)
		begin
			flen_d = 11'h001;
			nbits_d = 7'h00;
			case (state_q)
				SYNC_HUNT:
				begin
					if (framing_ok(fmt, meas_ratio, meas_bits))
					begin
						state_d = SYNC_CHECK;
						ratio_d = meas_ratio;
						bits_d = meas_bits;
					end
				end
				SYNC_CHECK, SYNC_LOCK:
				begin
					// A drift past the loss limit, a changed bit count or a stopped frame clock forces a resync
					if (drift > loss_lim || meas_bits != bits_q || flen_q == FLEN_MAX)
						state_d = SYNC_HUNT;
					else
						state_d = SYNC_LOCK;
				end
				default: state_d = SYNC_HUNT;
			endcase
		end
	end
	always_ff @(posedge ref_clk_i)
	begin
		if (core_rst)
		begin
			state_q <= SYNC_HUNT;
			ratio_q <= RATIO_NONE;
			bits_q <= 7'h00;
			flen_q <= 11'h000;
			nbits_q <= 7'h00;
		end
		else
		begin
			state_q <= state_d;
			ratio_q <= ratio_d;
			bits_q <= bits_d;
			flen_q <= flen_d;
			nbits_q <= nbits_d;
		end
	end

	// Output valid delay counted in frame periods after reset release
	logic [VCNT_W-1:0] vcnt_q, vcnt_d;
	logic valid_q, valid_d;
	always_comb
	begin
		vcnt_d = vcnt_q;
		valid_d = valid_q;
		if (frame_rise && !valid_q)
		begin
			if (vcnt_q == VCNT_LAST)
				valid_d = 1'b1;
			else
				vcnt_d = vcnt_q + 1'b1;
		end
	end
	always_ff @(posedge ref_clk_i)
	begin
		if (core_rst)
		begin
			vcnt_q <= '0;
			valid_q <= 1'b0;
		end
		else
		begin
			vcnt_q <= vcnt_d;
			valid_q <= valid_d;
		end
	end

	// Sample buffer
	stream_if #(.W(STEREO_W)) in_s ();
	stream_if #(.W(STEREO_W)) out_s ();
	assign in_s.valid = sample_valid_i;
	assign in_s.data = sample_data_i;
	assign sample_ready_o = in_s.ready;
	sample_fifo #(.W(STEREO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i (ref_clk_i),
		.rst_i (core_rst),
		.in_p (in_s),
		.out_p (out_s)
	);

	// High-pass filter, channel word selection and serialiser
	logic [AW-1:0] acc_q [2];
	logic [AW-1:0] acc_d [2];
	logic [15:0] chan_out [2];
	logic [15:0] hold_r_q, hold_r_d, shift_q, shift_d, word_now;
	logic serial_data_q, serial_data_d, fs_last_q, fs_last_d;
	logic left_level, word_edge, take, underrun_set;
	assign left_level = fmt ? !pin_q[2] : pin_q[2];
	assign word_edge = bclk_fall && (pin_q[2] != fs_last_q);
	assign take = word_edge && left_level && locked && valid_q;
	assign out_s.ready = take;
	assign underrun_set = take && !out_s.valid;
	always_comb
	begin
		logic [15:0] x;
		logic [15:0] avg;
		x = 16'h0000;
		avg = 16'h0000;
		for (int ch = 0; ch < 2; ch++)
		begin
			x = out_s.data[(1-ch)*SAMPLE_W +: SAMPLE_W];
			avg = acc_q[ch][AW-1:HPF_SHIFT];
			chan_out[ch] = dc_skip ? x : sat16({x[15], x} - {avg[15], avg});
			acc_d[ch] = acc_q[ch];
			if (take && out_s.valid)
				acc_d[ch] = acc_q[ch] + {{HPF_SHIFT{x[15]}}, x} - {{HPF_SHIFT{avg[15]}}, avg};
		end
		hold_r_d = hold_r_q;
		if (take)
			hold_r_d = out_s.valid ? chan_out[1] : BIPOLAR_ZERO_CODE;
		// Muted output is bipolar zero until valid and in sync
		if (!valid_q || !locked)
			word_now = BIPOLAR_ZERO_CODE;
		else if (left_level)
			word_now = out_s.valid ? chan_out[0] : BIPOLAR_ZERO_CODE;
		else
			word_now = hold_r_q;
		serial_data_d = serial_data_q;
		shift_d = shift_q;
		fs_last_d = fs_last_q;
		// Update only on a falling bit clock so the receiver samples on the rise
		if (word_edge)
		begin
			fs_last_d = pin_q[2];
			if (fmt)
			begin
				serial_data_d = 1'b0;
				shift_d = word_now;
			end
			else
			begin
				serial_data_d = word_now[15];
				shift_d = {word_now[14:0], 1'b0};
			end
		end
		else if (bclk_fall)
		begin
			serial_data_d = shift_q[15];
			shift_d = {shift_q[14:0], 1'b0};
		end
	end
	always_ff @(posedge ref_clk_i)
	begin
		if (core_rst)
		begin
			acc_q[0] <= '0;
			acc_q[1] <= '0;
			hold_r_q <= 16'h0000;
			shift_q <= 16'h0000;
			serial_data_q <= 1'b0;
			fs_last_q <= 1'b0;
		end
		else
		begin
			acc_q <= acc_d;
			hold_r_q <= hold_r_d;
			shift_q <= shift_d;
			serial_data_q <= serial_data_d;
			fs_last_q <= fs_last_d;
		end
	end
	assign serial_data_o = serial_data_q;

	// APB registers; read data is captured in the setup phase so it is a flop
	logic hit, wr_en, ctrl_hit, stat_hit, underrun_q, underrun_d;
	logic [31:0] prdata_q, prdata_d, status_word;
	assign ctrl_hit = (paddr_i == CTRL_OFS);
	assign stat_hit = (paddr_i == STATUS_OFS);
	assign hit = ctrl_hit || stat_hit;
	assign wr_en = psel_i && penable_i && pwrite_i && pstrb_i[0];
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !hit;
	assign prdata_o = prdata_q;
	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[ST_RESET_BIT] = por_busy_q;
		status_word[ST_VALID_BIT] = valid_q;
		status_word[ST_LOCK_BIT] = locked;
		status_word[ST_RATIO_LSB +: 2] = ratio_q;
		status_word[ST_BITS_LSB +: 7] = bits_q;
		status_word[ST_UNDERRUN_BIT] = underrun_q;
		ctrl_d = ctrl_q;
		if (wr_en && ctrl_hit)
			ctrl_d = pwdata_i[1:0];
		// A new underrun in the clearing cycle survives
		underrun_d = underrun_set || (underrun_q &&
			!(wr_en && stat_hit && pwdata_i[ST_UNDERRUN_BIT]));
		prdata_d = prdata_q;
		if (psel_i && !penable_i)
			prdata_d = ctrl_hit ? {30'h0000_0000, ctrl_q} : (stat_hit ? status_word : 32'h0);
	end
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q <= 2'h0;
			underrun_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			underrun_q <= underrun_d;
			prdata_q <= prdata_d;
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	a_por_length: assert property ($fell(por_busy_q) |-> $past(por_cnt_q) == POR_LAST)
		else $error("power-on hold ended at wrong count");
	a_reset_zero_out: assert property (por_busy_q |=> !serial_data_o)
		else $error("data driven during reset");
	a_valid_delay: assert property ($rose(valid_q) |-> $past(vcnt_q) == VCNT_LAST && $past(frame_rise))
		else $error("data valid at wrong frame count");
	a_loss_hunt: assert property (frame_rise && locked && drift > loss_lim |=> state_q == SYNC_HUNT)
		else $error("large drift did not drop sync");
	a_mute_unlocked: assert property (word_edge && !locked && !core_rst |=> !serial_data_o)
		else $error("unlocked frame not bipolar zero");
	a_small_drift_keep: assert property (frame_rise && locked && drift < keep_lim && meas_bits == bits_q
		&& flen_q != FLEN_MAX |=> locked)
		else $error("small drift caused resync");
	a_hunt_bad_frame: assert property (frame_rise && state_q == SYNC_HUNT
		&& !framing_ok(fmt, meas_ratio, meas_bits) |=> state_q == SYNC_HUNT)
		else $error("illegal framing accepted");
	a_lj_msb_first: assert property (word_edge && !fmt && !core_rst |=> serial_data_o == $past(word_now[15]))
		else $error("left-justified MSB not at frame edge");
	a_i2s_gap_bit: assert property (word_edge && fmt && !core_rst |=> !serial_data_o ##0 (!bclk_fall)[*2])
		else $error("I2S MSB not delayed one bit");
	a_fall_update: assert property ($changed(serial_data_o) && !$past(core_rst) |-> $past(bclk_fall))
		else $error("data changed off falling bit clock");
	a_skip_pass: assert property (take && dc_skip && out_s.valid |-> word_now == out_s.data[31:16])
		else $error("filter skip altered left word");
	c_lock: cover property ($rose(locked));
	c_valid: cover property ($rose(valid_q));
	c_loss: cover property ($fell(locked));
	c_i2s_word: cover property (take && fmt && out_s.valid);
endmodule // adc_serial_out

// [design/adc_serial_pkg.sv]
// Shared constants and types for the stereo converter serial output block
package adc_serial_pkg;
	// Sample and stream widths
	localparam int SAMPLE_W = 16;
	localparam int STEREO_W = 32;
	localparam int FIFO_DEPTH = 16;
	// Power-on hold and output valid delay
	localparam int POR_CYCLES = 1024;
	localparam logic [9:0] POR_LAST = 10'(POR_CYCLES - 1);
	localparam int VALID_FRAMES_DEF = 18436;
	localparam int VCNT_W = 15;
	// Synchronisation loss thresholds, in bit clocks
	localparam logic [2:0] LOSS_BITS = 3'h6;
	localparam logic [2:0] KEEP_BITS = 3'h5;
	// Frame measurement
	localparam int LEN_W = 11;
	localparam logic [10:0] FLEN_MAX = 11'h7FF;
	localparam logic [10:0] LEN_256 = 11'h100;
	localparam logic [10:0] LEN_384 = 11'h180;
	localparam logic [10:0] LEN_512 = 11'h200;
	localparam logic [10:0] LEN_TOL = 11'h002;
	localparam logic [6:0] BITS_64 = 7'h40;
	localparam logic [6:0] BITS_48 = 7'h30;
	localparam logic [6:0] BITS_32 = 7'h20;
	localparam logic [6:0] BITS_MAX = 7'h7F;
	// High-pass filter averaging shift
	localparam int HPF_SHIFT = 10;
	// Bipolar zero code for a two's complement word
	localparam logic [15:0] BIPOLAR_ZERO_CODE = 16'h0000;
	// APB register map
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam int CTRL_FMT_BIT = 0;
	localparam int CTRL_SKIP_BIT = 1;
	localparam int ST_RESET_BIT = 0;
	localparam int ST_VALID_BIT = 1;
	localparam int ST_LOCK_BIT = 2;
	localparam int ST_RATIO_LSB = 3;
	localparam int ST_BITS_LSB = 5;
	localparam int ST_UNDERRUN_BIT = 12;
	// Detected system clock ratio
	typedef enum logic [1:0] {
		RATIO_NONE = 2'b00,
		RATIO_256 = 2'b01,
		RATIO_384 = 2'b10,
		RATIO_512 = 2'b11
	} ratio_t;
	// Frame synchronisation states
	typedef enum logic [1:0] {
		SYNC_HUNT = 2'b00,
		SYNC_CHECK = 2'b01,
		SYNC_LOCK = 2'b10
	} sync_state_t;
endpackage

// [design/sample_fifo.sv]
// Synchronous FIFO buffering stereo sample words ahead of the serialiser
`timescale 1ns/1ns
module sample_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Streams
	stream_if.snk in_p,
	stream_if.src out_p
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	// Full and empty come straight from the fill count
	assign in_p.ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_p.valid = (cnt_q != '0);
	assign out_p.data = mem[rd_q];
	assign push = in_p.valid && in_p.ready;
	assign pop = out_p.valid && out_p.ready;

	// Pointer and count next values
	always_comb
	begin
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (push)
		begin
			wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
		end
		if (pop)
		begin
			rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
		end
		if (push && !pop)
		begin
			cnt_d = cnt_q + 1'b1;
		end
		else if (pop && !push)
		begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	// Pointer registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage has no reset; empty flag guards stale words
	always_ff @(posedge clk_i)
	begin
		if (push)
		begin
			mem[wr_q] <= in_p.data;
		end
	end
endmodule // sample_fifo

// [design/stream_if.sv]
// Valid/ready word stream between the block and its sample buffer
`timescale 1ns/1ns
interface stream_if #(parameter int W = 32);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	// Producer side
	modport src (output valid, output data, input ready);
	// Consumer side
	modport snk (input valid, input data, output ready);
endinterface
